/* File: pkg/dcp_pkg.sv */
// dcp_pkg: widths, encodings, timing counts and carrier types for the
// ddr3 channel pin interface.
// assumes a 100 MHz core clock and a free-running memory clock from a pll.
package dcp_pkg;

  // ****************************************************************
  // pin widths
  // ****************************************************************
  localparam int DQ_W = 64;
  localparam int ECC_W = 8;
  localparam int DQS_N = 18;
  localparam int DQS_X8_N = 9;
  localparam int ADDR_W = 16;
  localparam int BA_W = 3;
  localparam int CS_N = 8;
  localparam int CK_N = 4;
  localparam int ODT_N = 4;
  localparam int CKE_N = 4;
  localparam int SB_GROUPS = 2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int MCLK_KHZ = 100000;
  localparam int SB_KHZ = 100;
  // quarter of a sideband clock period, rounded down so the rate never falls below 100 kHz
  localparam int SB_QTR_CYC = MCLK_KHZ / (SB_KHZ * 4);
  localparam int FIFO_DEPTH = 16;
  localparam int RD_LAT = 2;

  // ****************************************************************
  // command encodings
  // ****************************************************************
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_ACT = 3'h1;
  localparam logic [2:0] OP_RD = 3'h2;
  localparam logic [2:0] OP_WR = 3'h3;
  localparam logic [2:0] OP_PRE = 3'h4;
  localparam logic [2:0] OP_MRS = 3'h5;
  // {ras_n, cas_n, we_n}
  localparam logic [2:0] STB_IDLE = 3'h7;
  localparam logic [2:0] STB_ACT = 3'h3;
  localparam logic [2:0] STB_RD = 3'h5;
  localparam logic [2:0] STB_WR = 3'h4;
  localparam logic [2:0] STB_PRE = 3'h2;
  localparam logic [2:0] STB_MRS = 3'h0;
  localparam logic [CS_N-1:0] CS_IDLE = 8'hff;
  localparam logic [DQS_N-1:0] DQS_X8_MASK = 18'h001ff;

  // ****************************************************************
  // sideband random byte read, one slot per scl period
  // ****************************************************************
  localparam logic [5:0] SB_SLOT_START = 6'h00;
  localparam logic [5:0] SB_SLOT_AW0 = 6'h01;
  localparam logic [5:0] SB_SLOT_PTR0 = 6'h0a;
  localparam logic [5:0] SB_SLOT_RSTART = 6'h13;
  localparam logic [5:0] SB_SLOT_AR0 = 6'h14;
  localparam logic [5:0] SB_SLOT_RD0 = 6'h1d;
  localparam logic [5:0] SB_SLOT_NACK = 6'h25;
  localparam logic [5:0] SB_SLOT_STOP = 6'h26;
  localparam logic [5:0] SB_BYTE_LEN = 6'h08;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [2:0] op;
    logic [2:0] rank;
    logic [BA_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] wdata;
    logic [ECC_W-1:0] wecc;
  } dcp_cmd_t;

  typedef struct packed {
    logic [DQ_W-1:0] data;
    logic [ECC_W-1:0] ecc;
  } dcp_rdata_t;

  typedef struct packed {
    logic [CS_N-1:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic par;
  } dcp_cmd_pins_t;

  typedef struct packed {
    logic start;
    logic [1:0] dev;
    logic [7:0] ptr;
  } dcp_sb_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic nack;
    logic [7:0] data;
  } dcp_sb_rsp_t;

endpackage : dcp_pkg

/* File: rtl/dcp_fifo.sv */
// dcp_fifo: single-clock flop fifo with valid/ready on both sides.
// assumes DEPTH is a power of two.
`timescale 1ns/1ps
module dcp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input logic clk_i,
  input logic resetn_i,
  input logic [W-1:0] in_data_i,
  input logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule : dcp_fifo

/* File: rtl/dcp_channel.sv */
// dcp_channel: one ddr3 memory channel at the pins, plus the two dimm
// sideband masters and the dram reset outputs of both channel groups.
// assumes ddr_clk_i runs free from a pll; core side is on mclk_i.
//
// Behaviour
// - three bank select bits name the bank of each activate, read, write, precharge.
// - four forwarded clock pairs; command pins change only at memory clock edges.
// - eight active-low chip selects, one rank selected per command.
// - 64 data bits per beat with 8 check bits driven alongside writes.
// - write strobes centred in the bit; read data taken at edge-aligned centre.
// - x4 devices use all eighteen strobe pairs, x8 devices only nine.
// - sixteen address bits carry row, column and configuration register values.
// - parity output makes address and command bits odd in total.
// - four termination enables, the rank's one on during read or write data.
// - active-low parity error input from registered dimm is watched and latched.
// - two dram reset outputs: one for channel 1, one for channels 2 and 3.
// - one sideband clock and data pair per channel group for spd and thermal sensor.
// - sideband clock runs at 100 kHz and never waits on stretched clock.
// - each sideband master addresses at most four slave devices.
`timescale 1ns/1ps
module dcp_channel
  import dcp_pkg::*;
#(
  parameter logic [6:0] SB_DEV_BASE = 7'h50,
  parameter int RL = dcp_pkg::RD_LAT
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ddr_clk_i,
  input dcp_pkg::dcp_cmd_t cmd_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  output dcp_pkg::dcp_rdata_t rd_o,
  output logic rd_valid_o,
  input wire logic dev_x4_i,
  input wire logic perr_clr_i,
  output logic perr_o,
  input wire logic dram_supply_good_group_a_i,
  input wire logic dram_supply_good_group_b_i,
  output logic dram_reset_group_a_n_o,
  output logic dram_reset_group_b_n_o,
  input dcp_pkg::dcp_sb_req_t [1:0] sb_req_i,
  output dcp_pkg::dcp_sb_rsp_t [1:0] sb_rsp_o,
  output logic [1:0] dimm_sideband_clk_o,
  output logic [1:0] dimm_sideband_clk_oe_n_o,
  input wire logic [1:0] dimm_sideband_dat_i,
  output logic [1:0] dimm_sideband_dat_o,
  output logic [1:0] dimm_sideband_dat_oe_n_o,
  output logic [3:0] ck_p_o,
  output logic [3:0] ck_n_o,
  output dcp_pkg::dcp_cmd_pins_t cmd_pins_o,
  output logic [3:0] odt_o,
  output logic [3:0] cke_o,
  output logic [63:0] dq_o,
  input wire logic [63:0] dq_i,
  output logic dq_oe_n_o,
  output logic [7:0] ecc_o,
  input wire logic [7:0] ecc_i,
  output logic ecc_oe_n_o,
  output logic [17:0] dqs_p_o,
  output logic [17:0] dqs_n_o,
  output logic [17:0] dqs_oe_n_o,
  input wire logic dimm_parity_error_in_n_i
);
  import dcp_pkg::*;

  typedef enum logic [3:0] {
    L_IDLE = 4'h1,
    L_WBEAT = 4'h2,
    L_RWAIT = 4'h4,
    L_RBEAT = 4'h8
  } dcp_lstate_t;

  // ****************************************************************
  // core side: queue and hand-off to the memory clock
  // ****************************************************************
  dcp_cmd_t f_dat;
  logic f_valid;
  logic pend_q;
  dcp_cmd_t hold_q;
  logic req_tgl_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_tgl_q;

  dcp_fifo #(.W($bits(dcp_cmd_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(mclk_i),
    .resetn_i(resetn_i),
    .in_data_i(cmd_i),
    .in_valid_i(cmd_valid_i),
    .in_ready_o(cmd_ready_o),
    .out_data_o(f_dat),
    .out_valid_o(f_valid),
    .out_ready_i(!pend_q)
  );

  always_ff @(posedge mclk_i) begin
    ack_s1_q <= ack_tgl_q;
    ack_s2_q <= ack_s1_q;
  end

  // hold_q stays still until the memory side has echoed the toggle
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pend_q <= 1'b0;
      req_tgl_q <= 1'b0;
      hold_q <= '0;
    end else if (f_valid && !pend_q) begin
      pend_q <= 1'b1;
      req_tgl_q <= !req_tgl_q;
      hold_q <= f_dat;
    end else if (ack_s2_q == req_tgl_q) begin
      pend_q <= 1'b0;
    end
  end

  // ****************************************************************
  // core side: read return, parity error, resets
  // ****************************************************************
  logic rd_tgl_q;
  logic rd_s1_q;
  logic rd_s2_q;
  logic rd_s3_q;
  dcp_rdata_t ldata_q;
  logic perr_s1_q;
  logic perr_s2_q;
  logic [1:0] sup_s1_q;
  logic [1:0] sup_s2_q;

  always_ff @(posedge mclk_i) begin
    rd_s1_q <= rd_tgl_q;
    rd_s2_q <= rd_s1_q;
    perr_s1_q <= dimm_parity_error_in_n_i;
    perr_s2_q <= perr_s1_q;
    sup_s1_q <= {dram_supply_good_group_b_i, dram_supply_good_group_a_i};
    sup_s2_q <= sup_s1_q;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rd_s3_q <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_o <= '0;
    end else begin
      rd_s3_q <= rd_s2_q;
      rd_valid_o <= rd_s2_q ^ rd_s3_q;
      if (rd_s2_q ^ rd_s3_q) begin
        rd_o <= ldata_q;
      end
    end
  end

  // a new error in the clearing cycle keeps the flag set
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      perr_o <= 1'b0;
    end else if (!perr_s2_q) begin
      perr_o <= 1'b1;
    end else if (perr_clr_i) begin
      perr_o <= 1'b0;
    end
  end

  // supply loss puts the drams back into reset
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      dram_reset_group_a_n_o <= 1'b0;
      dram_reset_group_b_n_o <= 1'b0;
    end else begin
      dram_reset_group_a_n_o <= sup_s2_q[0];
      dram_reset_group_b_n_o <= sup_s2_q[1];
    end
  end

  a_reset_held: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !sup_s2_q[0] |=> !dram_reset_group_a_n_o)
    else $error("dram reset released without supply good");
  a_perr_sticky: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !perr_s2_q |=> perr_o [*2])
    else $error("parity error not held");

  // ****************************************************************
  // memory clock side: synchronisers and command issue
  // ****************************************************************
  logic lrst_s1_q;
  logic lrst_n_q;
  logic req_s1_q;
  logic req_s2_q;
  logic x4_s1_q;
  logic x4_s2_q;
  logic cke_s1_q;
  logic cke_s2_q;
  logic take;
  dcp_lstate_t st_q;
  dcp_cmd_t lcmd_q;
  logic [2:0] stb;
  logic [7:0] rl_cnt_q;
  dcp_cmd_pins_t pins_q;
  logic lrst_off;

  always_ff @(posedge ddr_clk_i) begin
    lrst_s1_q <= resetn_i;
    lrst_n_q <= lrst_s1_q;
    req_s1_q <= req_tgl_q;
    req_s2_q <= req_s1_q;
    x4_s1_q <= dev_x4_i;
    x4_s2_q <= x4_s1_q;
    cke_s1_q <= dram_reset_group_a_n_o;
    cke_s2_q <= cke_s1_q;
  end

  assign take = (st_q == L_IDLE) && (req_s2_q != ack_tgl_q);
  assign ck_p_o = {CK_N{ddr_clk_i}};
  assign ck_n_o = {CK_N{!ddr_clk_i}};
  assign cmd_pins_o = pins_q;
  // the reset synchroniser starts unknown, so checks wait for both resets
  assign lrst_off = !resetn_i || !lrst_n_q;

  always_comb begin
    case (hold_q.op)
      OP_ACT: stb = STB_ACT;
      OP_RD: stb = STB_RD;
      OP_WR: stb = STB_WR;
      OP_PRE: stb = STB_PRE;
      OP_MRS: stb = STB_MRS;
      default: stb = STB_IDLE;
    endcase
  end

  always_ff @(posedge ddr_clk_i) begin
    if (!lrst_n_q) begin
      st_q <= L_IDLE;
      ack_tgl_q <= 1'b0;
      lcmd_q <= '0;
      rl_cnt_q <= '0;
    end else begin
      case (st_q)
        L_IDLE: begin
          if (take) begin
            ack_tgl_q <= req_s2_q;
            lcmd_q <= hold_q;
            rl_cnt_q <= '0;
            if (hold_q.op == OP_WR) begin
              st_q <= L_WBEAT;
            end else if (hold_q.op == OP_RD) begin
              st_q <= L_RWAIT;
            end
          end
        end
        L_WBEAT: st_q <= L_IDLE;
        L_RWAIT: begin
          rl_cnt_q <= rl_cnt_q + 8'h01;
          if (rl_cnt_q == 8'(RL - 1)) begin
            st_q <= L_RBEAT;
          end
        end
        L_RBEAT: st_q <= L_IDLE;
        default: st_q <= L_IDLE;
      endcase
    end
  end

  // pins change only at the rising memory clock edge
  always_ff @(posedge ddr_clk_i) begin
    if (!lrst_n_q) begin
      pins_q <= '{cs_n: CS_IDLE, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                  ba: '0, addr: '0, par: 1'b0};
    end else if (take && stb != STB_IDLE) begin
      pins_q.cs_n <= ~(8'h01 << hold_q.rank);
      {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= stb;
      pins_q.ba <= hold_q.bank;
      pins_q.addr <= hold_q.addr;
      pins_q.par <= ~^{hold_q.addr, hold_q.bank, stb};
    end else begin
      pins_q.cs_n <= CS_IDLE;
      {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= STB_IDLE;
      pins_q.par <= ~^{pins_q.addr, pins_q.ba, STB_IDLE};
    end
  end

  // termination spans the command cycle and the data beat
  always_ff @(posedge ddr_clk_i) begin
    if (!lrst_n_q) begin
      odt_o <= '0;
      cke_o <= '0;
    end else begin
      cke_o <= {CKE_N{cke_s2_q}};
      if (take && (hold_q.op == OP_WR || hold_q.op == OP_RD)) begin
        odt_o <= 4'h1 << hold_q.rank[2:1];
      end else if (st_q == L_IDLE) begin
        odt_o <= '0;
      end
    end
  end

  // ****************************************************************
  // memory clock side: data and strobes
  // ****************************************************************
  logic dqs_lvl_q;
  logic dqs_drv_q;
  logic [63:0] dq_neg_q;
  logic [7:0] ecc_neg_q;
  logic [17:0] dqs_mask;

  assign dqs_mask = x4_s2_q ? {DQS_N{1'b1}} : DQS_X8_MASK;
  assign dqs_p_o = {DQS_N{dqs_lvl_q}} & dqs_mask;
  assign dqs_n_o = ~dqs_p_o;
  assign dqs_oe_n_o = ~({DQS_N{dqs_drv_q}} & dqs_mask);

  always_ff @(posedge ddr_clk_i) begin
    if (!lrst_n_q) begin
      dq_oe_n_o <= 1'b1;
      ecc_oe_n_o <= 1'b1;
      dq_o <= '0;
      ecc_o <= '0;
      dqs_drv_q <= 1'b0;
    end else begin
      dq_oe_n_o <= (st_q != L_WBEAT);
      ecc_oe_n_o <= (st_q != L_WBEAT);
      dqs_drv_q <= (st_q == L_WBEAT) || !dq_oe_n_o;
      if (st_q == L_WBEAT) begin
        dq_o <= lcmd_q.wdata;
        ecc_o <= lcmd_q.wecc;
      end
    end
  end

  // falling edge sits mid-bit: launches the write strobe centred, and
  // samples edge-aligned read data at its centre
  always_ff @(negedge ddr_clk_i) begin
    if (!lrst_n_q) begin
      dqs_lvl_q <= 1'b0;
    end else begin
      dqs_lvl_q <= !dq_oe_n_o;
    end
    dq_neg_q <= dq_i;
    ecc_neg_q <= ecc_i;
  end

  always_ff @(posedge ddr_clk_i) begin
    if (!lrst_n_q) begin
      ldata_q <= '0;
      rd_tgl_q <= 1'b0;
    end else if (st_q == L_RBEAT) begin
      ldata_q <= '{data: dq_neg_q, ecc: ecc_neg_q};
      rd_tgl_q <= !rd_tgl_q;
    end
  end

  sequence s_wr_take;
    take && hold_q.op == OP_WR;
  endsequence
  sequence s_wr_beat;
    !dq_oe_n_o && !ecc_oe_n_o && odt_o != '0;
  endsequence

  a_strobe_cs: assert property (@(posedge ddr_clk_i) disable iff (lrst_off)
    {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} != STB_IDLE |-> pins_q.cs_n != CS_IDLE)
    else $error("command strobe without chip select");
  a_one_rank: assert property (@(posedge ddr_clk_i) disable iff (lrst_off)
    $onehot0(~pins_q.cs_n))
    else $error("more than one rank selected");
  a_odd_parity: assert property (@(posedge ddr_clk_i) disable iff (lrst_off)
    ^{pins_q.addr, pins_q.ba, pins_q.ras_n, pins_q.cas_n, pins_q.we_n, pins_q.par})
    else $error("address command parity not odd");
  a_bank_addr: assert property (@(posedge ddr_clk_i) disable iff (lrst_off)
    take && stb != STB_IDLE |=> pins_q.ba == $past(hold_q.bank)
      && pins_q.addr == $past(hold_q.addr))
    else $error("bank or address not issued");
  a_write_beat: assert property (@(posedge ddr_clk_i) disable iff (lrst_off)
    s_wr_take |=> odt_o != '0 ##1 s_wr_beat ##1 dq_oe_n_o && dqs_drv_q)
    else $error("write beat misplaced");
  a_read_odt: assert property (@(posedge ddr_clk_i) disable iff (lrst_off)
    take && hold_q.op == OP_RD |=> (odt_o != '0) [*2])
    else $error("termination off during read");
  a_x8_mask: assert property (@(posedge ddr_clk_i) disable iff (lrst_off)
    !x4_s2_q |-> &dqs_oe_n_o[17:9])
    else $error("upper strobes driven for x8 devices");

  // ****************************************************************
  // sideband masters, one per channel group
  // ****************************************************************
  function automatic logic sb_sda_rel(input logic [5:0] s, input logic [1:0] q,
                                      input logic [7:0] aw, input logic [7:0] pt);
    logic [5:0] off;
    logic [7:0] b;
    logic r;
    off = 6'h00;
    b = 8'h00;
    r = 1'b1;
    if (s == SB_SLOT_START || s == SB_SLOT_RSTART) begin
      r = (q < 2'h2);
    end else if (s == SB_SLOT_STOP) begin
      r = (q >= 2'h2);
    end else if (s >= SB_SLOT_AW0 && s < SB_SLOT_AW0 + SB_BYTE_LEN) begin
      off = s - SB_SLOT_AW0;
      r = aw[3'h7 - off[2:0]];
    end else if (s >= SB_SLOT_PTR0 && s < SB_SLOT_PTR0 + SB_BYTE_LEN) begin
      off = s - SB_SLOT_PTR0;
      r = pt[3'h7 - off[2:0]];
    end else if (s >= SB_SLOT_AR0 && s < SB_SLOT_AR0 + SB_BYTE_LEN) begin
      off = s - SB_SLOT_AR0;
      b = aw | 8'h01;
      r = b[3'h7 - off[2:0]];
    end
    return r;
  endfunction : sb_sda_rel

  localparam logic [7:0] SB_QTR_LAST = 8'(SB_QTR_CYC - 1);
  localparam int SB_QTR_MID = SB_QTR_CYC - 2;

  for (genvar g = 0; g < SB_GROUPS; g++) begin : g_sb
    logic busy_q;
    logic done_q;
    logic nack_q;
    logic [5:0] slot_q;
    logic [1:0] qtr_q;
    logic [7:0] tick_q;
    logic [7:0] aw_q;
    logic [7:0] ptr_q;
    logic [7:0] shift_q;
    logic scl_low_q;
    logic sda_low_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic scl_rel;
    logic qend;

    assign qend = busy_q && tick_q == SB_QTR_LAST;
    assign scl_rel = (slot_q == SB_SLOT_START) ? (qtr_q != 2'h3) :
                     (slot_q == SB_SLOT_STOP) ? (qtr_q != 2'h0) :
                     (qtr_q == 2'h1 || qtr_q == 2'h2);
    assign dimm_sideband_clk_o[g] = 1'b0;
    assign dimm_sideband_clk_oe_n_o[g] = !scl_low_q;
    assign dimm_sideband_dat_o[g] = 1'b0;
    assign dimm_sideband_dat_oe_n_o[g] = !sda_low_q;
    assign sb_rsp_o[g] = '{busy: busy_q, done: done_q, nack: nack_q, data: shift_q};

    always_ff @(posedge mclk_i) begin
      sda_s1_q <= dimm_sideband_dat_i[g];
      sda_s2_q <= sda_s1_q;
    end

    // clock is driven blind: a stretched low clock is never waited for
    always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
        busy_q <= 1'b0;
        done_q <= 1'b0;
        nack_q <= 1'b0;
        slot_q <= '0;
        qtr_q <= '0;
        tick_q <= '0;
        aw_q <= '0;
        ptr_q <= '0;
        shift_q <= '0;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
      end else begin
        done_q <= 1'b0;
        scl_low_q <= busy_q && !scl_rel;
        sda_low_q <= busy_q && !sb_sda_rel(slot_q, qtr_q, aw_q, ptr_q);
        if (!busy_q && sb_req_i[g].start) begin
          busy_q <= 1'b1;
          nack_q <= 1'b0;
          slot_q <= SB_SLOT_START;
          qtr_q <= 2'h0;
          tick_q <= 8'h00;
          aw_q <= {SB_DEV_BASE[6:2], sb_req_i[g].dev, 1'b0};
          ptr_q <= sb_req_i[g].ptr;
        end else if (busy_q) begin
          tick_q <= qend ? 8'h00 : tick_q + 8'h01;
          if (qend) begin
            qtr_q <= qtr_q + 2'h1;
            if (qtr_q == 2'h2) begin
              if (slot_q >= SB_SLOT_RD0 && slot_q < SB_SLOT_NACK) begin
                shift_q <= {shift_q[6:0], sda_s2_q};
              end
              if ((slot_q == SB_SLOT_AW0 + SB_BYTE_LEN || slot_q == SB_SLOT_PTR0 + SB_BYTE_LEN
                   || slot_q == SB_SLOT_AR0 + SB_BYTE_LEN) && sda_s2_q) begin
                nack_q <= 1'b1;
              end
            end
            if (qtr_q == 2'h3) begin
              slot_q <= slot_q + 6'h01;
              if (slot_q == SB_SLOT_STOP) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            end
          end
        end
      end
    end

    a_sb_quarter: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      busy_q && tick_q == 8'h00 && !qend |=> tick_q == 8'h01 ##SB_QTR_MID qend)
      else $error("sideband quarter period wrong");
    a_sb_four_dev: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      busy_q |-> aw_q[7:3] == SB_DEV_BASE[6:2])
      else $error("sideband address outside four devices");
  end

endmodule : dcp_channel

/* File: dv/dcp_dimm_model.sv */
// dcp_dimm_model: behavioural dimm ranks on one channel's command and data pins.
// assumes a free-running memory clock; keeps 16 words indexed by low address bits.
`timescale 1ns/1ps
module dcp_dimm_model
  import dcp_pkg::*;
#(
  parameter int RL = 2
) (
  input wire logic clk_i,
  input dcp_pkg::dcp_cmd_pins_t pins_i,
  input wire logic [71:0] wr_i,
  input wire logic oe_n_i,
  output logic [71:0] rd_o
);
  logic [71:0] mem [16];
  logic [3:0] wa;
  logic [3:0] ra;
  logic [2:0] stb;
  logic sel;
  int cnt = 0;
  assign sel = pins_i.cs_n != CS_IDLE;
  assign stb = {pins_i.ras_n, pins_i.cas_n, pins_i.we_n};
  initial rd_o = '0;
  always @(posedge clk_i) begin
    if (sel && stb == STB_WR) wa <= pins_i.addr[3:0];
    if (!oe_n_i) mem[wa] <= wr_i;
    // outside the data beat the bus toggles, so a stale word never matches
    rd_o <= (cnt == 1) ? mem[ra] : ~rd_o;
    cnt <= (cnt > 0) ? cnt - 1 : 0;
    if (sel && stb == STB_RD) begin
      ra <= pins_i.addr[3:0];
      cnt <= RL - 1;
    end
  end
endmodule : dcp_dimm_model

/* File: dv/tb.sv */
// tb: random write/read traffic, pin monitors, reset, parity error, sideband.
// assumes dcp_dimm_model on the far side and pulled-up sideband data lines.
`timescale 1ns/1ps
module tb;
  import dcp_pkg::*;
  logic mclk = 0, dclk = 0, resetn = 0, valid = 0, x4 = 0, pclr = 0;
  logic ga = 0, gb = 0, perr_n = 1, rdy, rdv, perr, rsta, rstb, oe;
  dcp_cmd_t cmd = '0;
  dcp_rdata_t rd;
  dcp_sb_req_t [1:0] sb = '0;
  dcp_sb_rsp_t [1:0] sbr;
  dcp_cmd_pins_t pins;
  wire [1:0] sda;
  logic [71:0] wd, rdd, exp [6];
  logic [17:0] dqsoe;
  logic [3:0] odt, cke;
  int n_errors = 0, check_count = 0;
  initial forever #5 mclk = ~mclk;
  initial #3 forever #16 dclk = ~dclk;
  dcp_channel dcp_channel_inst (.mclk_i(mclk), .resetn_i(resetn), .ddr_clk_i(dclk),
    .cmd_i(cmd), .cmd_valid_i(valid), .cmd_ready_o(rdy), .rd_o(rd), .rd_valid_o(rdv),
    .dev_x4_i(x4), .perr_clr_i(pclr), .perr_o(perr), .dram_supply_good_group_a_i(ga),
    .dram_supply_good_group_b_i(gb), .dram_reset_group_a_n_o(rsta),
    .dram_reset_group_b_n_o(rstb), .sb_req_i(sb), .sb_rsp_o(sbr), .dimm_sideband_clk_o(),
    .dimm_sideband_clk_oe_n_o(), .dimm_sideband_dat_i(sda), .dimm_sideband_dat_o(),
    .dimm_sideband_dat_oe_n_o(sda), .ck_p_o(), .ck_n_o(), .cmd_pins_o(pins), .odt_o(odt),
    .cke_o(cke), .dq_o(wd[71:8]), .dq_i(rdd[71:8]), .dq_oe_n_o(oe), .ecc_o(wd[7:0]),
    .ecc_i(rdd[7:0]), .ecc_oe_n_o(), .dqs_p_o(), .dqs_n_o(), .dqs_oe_n_o(dqsoe),
    .dimm_parity_error_in_n_i(perr_n));
  dcp_dimm_model dcp_dimm_model_inst (.clk_i(dclk), .pins_i(pins), .wr_i(wd),
    .oe_n_i(oe), .rd_o(rdd));
  task automatic chk(string nm, logic [71:0] e, logic [71:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic tmo();
    chk("wait", 1, 0);
    report_and_stop();
  endtask : tmo
  task automatic send(logic [2:0] op, logic [3:0] a, logic [71:0] d);
    @(negedge mclk);
    cmd = '{op, 3'($urandom), 3'($urandom), {12'h0, a}, d[71:8], d[7:0]};
    valid = 1;
    for (int t = 0; rdy !== 1; t++) begin
      if (t > 200) tmo();
      @(negedge mclk);
    end
    @(negedge mclk);
    valid = 0;
  endtask : send
  // **********
  // pin monitors
  // **********
  always @(negedge dclk) if (resetn) begin
    chk("par", 1, ^{pins.addr, pins.ba, pins.ras_n, pins.cas_n, pins.we_n, pins.par});
    if ({pins.ras_n, pins.cas_n, pins.we_n} != STB_IDLE) chk("cs", 1, $countones(~pins.cs_n));
    if (!x4) chk("dqs", 9'h1ff, dqsoe[17:9]);
    else if (!oe) chk("dqs", 18'h0, dqsoe);
    if (!oe) chk("odt", 1, odt != 4'h0);
  end
  initial begin
    void'($urandom(92218));
    repeat (10) @(negedge mclk);
    resetn = 1;
    ga = 1;
    chk("rsta", 0, rsta);
    repeat (6) @(negedge mclk);
    chk("rsta", 1, rsta);
    chk("rstb", 0, rstb);
    gb = 1;
    repeat (40) @(negedge mclk);
    chk("rstb", 1, rstb);
    chk("cke", 4'hf, cke);
    for (int r = 0; r < 2; r++) begin
      x4 = r[0];
      // no reads here: a stray read return would be taken for the first checked one
      foreach (exp[i]) send(i % 3 == 0 ? OP_ACT : (i % 3 == 1 ? OP_PRE : OP_MRS),
                            4'($urandom), '0);
      foreach (exp[i]) begin
        exp[i] = {$urandom, $urandom, 8'($urandom)};
        send(OP_WR, 4'(i), exp[i]);
      end
      foreach (exp[i]) begin
        send(OP_RD, 4'(i), '0);
        for (int t = 0; rdv !== 1; t++) begin
          if (t > 300) tmo();
          @(negedge mclk);
        end
        chk("rdata", exp[i], rd);
      end
    end
    perr_n = 0;
    repeat (2) @(negedge mclk);
    perr_n = 1;
    repeat (4) @(negedge mclk);
    chk("perr", 1, perr);
    pclr = 1;
    @(negedge mclk) pclr = 0;
    @(negedge mclk) chk("perr", 0, perr);
    sb = {11'h400 | 11'($urandom), 11'h400 | 11'($urandom)};
    @(negedge mclk) sb = '0;
    for (int t = 0; sbr[0].done !== 1; t++) begin
      if (t > 41000) tmo();
      @(negedge mclk);
    end
    // nobody acks on a pulled-up line, so both masters report a nack and ff
    chk("sb", 11'h7fe, {sbr[0].nack, sbr[0].data, sbr[1].nack, sbr[1].busy});
    ga = 0;
    repeat (6) @(negedge mclk);
    chk("rsta", 0, rsta);
    report_and_stop();
  end
endmodule : tb
